// *** verilog/prc_map.svh ***
// constants for the presettable ripple counter
// assumes a 250 MHz system clock
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
`define PRC_CLK_PERIOD_PS 4000
`define PRC_WIDTH 4
`define PRC_MOD_BINARY 2'h0
`define PRC_MOD_DECADE 2'h1
`define PRC_MOD_TWELVE 2'h2
`define PRC_STROBE_REL_NS 30
`define PRC_RESET_REL_NS 50
`define PRC_STROBE_REL_CYC \
    ((`PRC_STROBE_REL_NS * 1000 + `PRC_CLK_PERIOD_PS - 1) \
    / `PRC_CLK_PERIOD_PS)
`define PRC_RESET_REL_CYC \
    ((`PRC_RESET_REL_NS * 1000 + `PRC_CLK_PERIOD_PS - 1) \
    / `PRC_CLK_PERIOD_PS)
`define PRC_RESET_VAL 4'h0
`endif

// *** verilog/prc_pkg.sv ***
// types for the presettable ripple counter
// assumes prc_map.svh is on the include path
`include "prc_map.svh"
package prc_pkg;
    typedef enum logic [1:0]
    {
        PRC_MOD_BIN_E = `PRC_MOD_BINARY,
        PRC_MOD_DEC_E = `PRC_MOD_DECADE,
        PRC_MOD_TWL_E = `PRC_MOD_TWELVE
    } prc_mod_e;
    typedef struct packed
    {
        logic clk_first;
        logic clk_upper;
        logic load_n;
        logic clear_n;
        logic [`PRC_WIDTH-1:0] data;
    } prc_pins_s;
    typedef logic [`PRC_WIDTH-1:0] prc_count_t;
endpackage : prc_pkg

// *** verilog/prc_sync.sv ***
// two-flop synchroniser for the pin inputs of the counter
// assumes one system clock, synchronous active-low reset
`timescale 1ns/1ps
module prc_sync
    import prc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire prc_pins_s i_pins,
    output prc_pins_s o_pins
);
    prc_pins_s meta_reg;
    prc_pins_s meta_next;
    prc_pins_s sync_reg;
    prc_pins_s sync_next;

    always_comb
    begin
        meta_next = i_pins;
        sync_next = meta_reg;
    end

    // idle pins: clocks low, strobe and clear released
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            meta_reg <= '{1'b0, 1'b0, 1'b1, 1'b1, 4'h0};
            sync_reg <= '{1'b0, 1'b0, 1'b1, 1'b1, 4'h0};
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_pins = sync_reg;
endmodule : prc_sync

// *** verilog/prc_counter.sv ***
// presettable four-stage ripple counter, modelled on the system clock
// assumes pins come from outside and are synchronised here
// Behaviour
// - four presettable stages, each with an output and a data input
// - modulus selectable: 16 binary, 10 decade, 12 divide-by-twelve
// - first stage has its own clock apart from upper three stages
// - stages count only on falling edge of their clock
// - strobe low blocks all clock edges
// - strobe low copies data inputs onto outputs by level
// - clear low forces all outputs to zero
// - clear dominates clocks and strobe
// - without clocks a loaded value is held
// - upper stages ripple on falling edge of preceding output
`timescale 1ns/1ps
module prc_counter
    import prc_pkg::*;
#(
    parameter prc_mod_e MODULUS = PRC_MOD_BIN_E
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_first,
    input wire logic i_clk_upper,
    input wire logic i_load_n,
    input wire logic i_clear_n,
    input wire logic [3:0] i_data,
    output logic [3:0] o_count,
    output logic o_ready
);
    // ****************************************
    // input synchronisation
    // ****************************************
    prc_pins_s pins_raw;
    prc_pins_s pins;

    assign pins_raw = '{i_clk_first, i_clk_upper, i_load_n, i_clear_n,
                        i_data};

    prc_sync u_sync
    (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_pins(pins_raw),
        .o_pins(pins)
    );

    // ****************************************
    // state
    // ****************************************
    prc_count_t q_reg;
    prc_count_t q_next;
    logic c1_reg;
    logic c1_next;
    logic c2_reg;
    logic c2_next;
    logic [4:0] hold_reg;
    logic [4:0] hold_next;
    logic ready_reg;
    logic ready_next;

    // ****************************************
    // stage helpers
    // ****************************************
    // the real part is level sensitive inside each stage: the master
    // opens while the clock is high and the slave follows on the fall.
    // here the clock pins are sampled, so a fall is seen as a high
    // sample followed by a low one on consecutive system clocks.
    // a clock pulse shorter than one system period can be missed;
    // the driver must keep each level for at least one sampled cycle.

    // one stage of the ripple chain: toggles on a falling clock
    function automatic logic stage_fall(input logic prev, input logic now);
        stage_fall = prev & ~now;
    endfunction : stage_fall

    // advance upper three stages on one falling edge of their clock
    function automatic logic [2:0] upper_step(input logic [2:0] u);
        logic [2:0] r;
        r = u;
        case (MODULUS)
            PRC_MOD_DEC_E:
            begin
                // divide by five: 0..4 then wrap
                r = (u == 3'h4) ? 3'h0 : u + 3'h1;
            end
            PRC_MOD_TWL_E:
            begin
                // middle stage divides by three, top by two
                if (u[1:0] == 2'h2)
                begin
                    r = {~u[2], 2'h0};
                end
                else
                begin
                    r = {u[2], u[1:0] + 2'h1};
                end
            end
            default:
            begin
                r = u + 3'h1;
            end
        endcase
        upper_step = r;
    endfunction : upper_step

    // ****************************************
    // next state
    // ****************************************
    // priority follows the pins: clear over strobe over clocks.
    // clock samples keep tracking while strobe or clear is low, so a
    // fall that happened while blocked is simply lost, not replayed.
    // the release counter only drives o_ready; edges that arrive
    // while it runs are still taken, the driver owns the spacing.
    // illegal states (above nine in decade) still step by the same
    // upper rule, so a bad preset walks back into the count.
    always_comb
    begin
        q_next = q_reg;
        c1_next = pins.clk_first;
        c2_next = pins.clk_upper;
        hold_next = (hold_reg != 5'h0) ? hold_reg - 5'h1 : 5'h0;
        if (!pins.clear_n)
        begin
            q_next = `PRC_RESET_VAL;
            hold_next = 5'(`PRC_RESET_REL_CYC);
        end
        else if (!pins.load_n)
        begin
            q_next = pins.data;
            if (hold_reg < 5'(`PRC_STROBE_REL_CYC))
            begin
                hold_next = 5'(`PRC_STROBE_REL_CYC);
            end
        end
        else
        begin
            // edges remembered while blocked are not replayed
            if (stage_fall(c1_reg, pins.clk_first))
            begin
                q_next[0] = ~q_reg[0];
            end
            if (stage_fall(c2_reg, pins.clk_upper))
            begin
                q_next[3:1] = upper_step(q_reg[3:1]);
            end
        end
        ready_next = (hold_next == 5'h0);
    end

    // ****************************************
    // registers
    // ****************************************
    // system reset matches the pin idle state so that no false
    // falling edge is seen on either clock when reset is released.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            q_reg <= `PRC_RESET_VAL;
            c1_reg <= 1'b0;
            c2_reg <= 1'b0;
            hold_reg <= 5'h0;
            ready_reg <= 1'b1;
        end
        else
        begin
            q_reg <= q_next;
            c1_reg <= c1_next;
            c2_reg <= c2_next;
            hold_reg <= hold_next;
            ready_reg <= ready_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // upper stages still lag the first stage by the outside ripple path,
    // so a decoder should wait a few system clocks after each count.
    // outputs are registered per system clock, but the upper three follow bit 0 three clocks later
    assign o_count = q_reg;
    assign o_ready = ready_reg;
endmodule : prc_counter

// *** sim/prc_chk_sva.sv ***
// port checker for the ripple counter
// assumes it is bound onto prc_counter
`timescale 1ns/1ps
module prc_chk
    import prc_pkg::*;
#(parameter prc_mod_e MODULUS = PRC_MOD_BIN_E)
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_first,
    input wire logic i_clk_upper,
    input wire logic i_load_n,
    input wire logic i_clear_n,
    input wire logic [3:0] i_data,
    input wire logic [3:0] o_count
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence s_q; (i_clear_n && i_load_n)[*4]; endsequence
    a_clear_zero: assert property (!i_clear_n[*4] |=> o_count == 4'h0)
        else $error("clear");
    a_clear_beats: assert property ((!i_clear_n && !i_load_n)[*4] |=> !o_count)
        else $error("clear wins");
    a_load_copy: assert property ((i_clear_n && !i_load_n && $stable(i_data))[*4]
        |=> o_count == $past(i_data)) else $error("load");
    a_bit0_step: assert property (s_q ##0 $fell(i_clk_first) ##1 s_q
        |-> o_count[0] != $past(o_count[0], 4)) else $error("bit0");
    a_upper_step: assert property (s_q ##0 $fell(i_clk_upper) ##1 s_q
        |-> o_count[3:1] != $past(o_count[3:1], 4)) else $error("upper");
    a_bit0_hold: assert property ((i_clear_n && i_load_n &&
        !$fell(i_clk_first))[*4] |=> $stable(o_count[0])) else $error("hold0");
    a_upper_hold: assert property ((i_clear_n && i_load_n &&
        !$fell(i_clk_upper))[*4] |=> $stable(o_count[3:1])) else $error("hold");
    a_reset_zero: assert property (@(posedge i_clk_sys) disable iff (1'b0)
        !i_reset_n |=> o_count == 4'h0) else $error("reset");
endmodule : prc_chk
bind prc_counter prc_chk #(.MODULUS(MODULUS)) u_chk (.*);

// *** sim/prc_far.sv ***
// far side: board wiring of the upper clock
// assumes settled registered outputs
`timescale 1ns/1ps
module prc_far
(
    input wire logic i_q0,
    output logic o_clk
);
    assign o_clk = i_q0;
endmodule : prc_far

// *** sim/tb_top.sv ***
// testbench: all three moduli side by side
// assumes prc_far closes the ripple link
`timescale 1ns/1ps
module tb_top;
    import prc_pkg::*;
    logic clk = 0, rst_n = 0, c1 = 1, ld_n = 1, cl_n = 0;
    logic [3:0] d = 4'h0;
    logic [3:0] q [3];
    logic [3:0] e [3];
    logic r [3];
    int failures = 0, checks = 0, seed = 32'h080a2ccd, n;
    initial forever #2 clk = ~clk;
    for (genvar i = 0; i < 3; i++)
    begin : g
        logic up;
        prc_far far (.i_q0(q[i][0]), .o_clk(up));
        prc_counter #(.MODULUS(prc_mod_e'(i))) uut (.i_clk_sys(clk),
            .i_reset_n(rst_n), .i_clk_first(c1), .i_clk_upper(up),
            .i_load_n(ld_n), .i_clear_n(cl_n), .i_data(d),
            .o_count(q[i]), .o_ready(r[i]));
    end
    function automatic logic [3:0] step(logic [3:0] c, int m);
        logic [2:0] u;
        u = c[3:1];
        if (c[0])
            u = (m == 0) ? u + 3'h1 : (m == 1) ? ((u == 3'h4) ? 3'h0 : u + 3'h1)
                : ((u[1:0] == 2'h2) ? {~u[2], 2'h0}
                : {u[2], u[1:0] + 2'h1});
        return {u, ~c[0]};
    endfunction : step
    task automatic cmp(logic [3:0] s, logic [3:0] x);
        checks++;
        if (s !== x)
        begin
            failures++;
            $display("[ERR] count exp %h got %h", x, s);
        end
    endtask : cmp
    task automatic cyc(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    initial
    begin
        cyc(10);
        rst_n = 1;
        cyc(14);
        for (int i = 0; i < 3; i++) e[i] = 4'h0;
        for (int i = 0; i < 3; i++) cmp(q[i], e[i]);
        cl_n = 1;
        cyc(14);
        for (int k = 0; k < 6; k++)
        begin
            d = (k == 0) ? 4'h5 : 4'($random(seed));
            ld_n = 0;
            cyc(2);
            c1 = 0;
            cyc(4);
            c1 = 1;
            cyc(6);
            ld_n = 1;
            cyc(14);
            for (int i = 0; i < 3; i++) e[i] = d;
            for (int i = 0; i < 3; i++) cmp(q[i], e[i]);
            n = (k == 0) ? 23 : {$random(seed)} % 24;
            repeat (n)
            begin
                c1 = 0;
                cyc(8);
                c1 = 1;
                cyc(4);
                for (int i = 0; i < 3; i++) e[i] = step(e[i], i);
            end
            cyc(8);
            for (int i = 0; i < 3; i++) cmp(q[i], e[i]);
            cl_n = 0;
            ld_n = 0;
            cyc(6);
            for (int i = 0; i < 3; i++) cmp(q[i], 4'h0);
            for (int i = 0; i < 3; i++) cmp({3'h0, r[i]}, 4'h0);
            ld_n = 1;
            cl_n = 1;
            cyc(16);
            for (int i = 0; i < 3; i++) cmp({3'h0, r[i]}, 4'h1);
            $display("pass %0d done", k);
        end
        summarize();
    end
    initial
    begin
        cyc(5000);
        failures++;
        summarize();
    end
endmodule : tb_top
